// ### core/tsal_pkg.sv
// Constants and register layout of the thermal alarm configuration and limit block
//--------------------------------------------------------------------
// Behaviour
// - Config bits 15..11 read zero, writes ignored
// - Hysteresis field selects off, 1.5, 3, 6 degrees
// - Hysteresis applies only while temperature falls
// - Any lock freezes the hysteresis field
// - Sleep stops sampling, data updates and events
// - Locked sleep cannot be set, always clearable
// - Registers stay reachable while sleeping
// - Critical lock sticky until reset, blocks critical limit
// - Window lock sticky until reset, freezes limits
// - Clear bit releases latched alarm, reads zero
// - Status bit shows alarm currently asserted
// - Enable bit gates alarm output, lock freezes
// - Critical-only bit drops window, window lock freezes
// - Polarity bit sets asserted level, lock freezes
// - Mode bit picks comparator or interrupt, lock freezes
// - Limits are two's complement, sign at B12
// - Comparisons use B12..B2 only
// - Upper limit at pointer 02, window-locked
// - Lower limit at pointer 03, window-locked
// - Critical alarm holds until limit minus hysteresis in comparator mode; in interrupt mode a clear releases it
// - Bus address 0011 plus select, two bytes
//--------------------------------------------------------------------
package tsal_pkg;

  // Register pointers
  localparam logic [7:0] PTR_ALARM_CONTROL = 8'h01;
  localparam logic [7:0] PTR_UPPER_LIMIT = 8'h02;
  localparam logic [7:0] PTR_LOWER_LIMIT = 8'h03;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Bus address: fixed upper nibble, low three bits from the select strap
  localparam logic [3:0] DEV_ADDR_HI = 4'h3;

  // Alarm control field positions
  localparam int CFG_HYSTERESIS_SELECT_HI = 10;
  localparam int CFG_HYSTERESIS_SELECT_LO = 9;
  localparam int CFG_SLEEP = 8;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_WIN_LOCK = 6;
  localparam int CFG_CLEAR = 5;
  localparam int CFG_STATUS = 4;
  localparam int CFG_ENABLE = 3;
  localparam int CFG_CRIT_ONLY = 2;
  localparam int CFG_POLARITY = 1;
  localparam int CFG_MODE = 0;

  // Limit field: B12..B2 are the only stored and compared bits
  localparam int LIM_MSB = 12;
  localparam int LIM_LSB = 2;

  // Reset values
  localparam logic [15:0] ALARM_CONTROL_RESET = 16'h0000;
  localparam logic [10:0] LIMIT_RESET = 11'h000;

  // Hysteresis in quarter-degree steps
  localparam logic [1:0] HYSTERESIS_SELECT_OFF = 2'h0;
  localparam logic [1:0] HYSTERESIS_SELECT_1P5 = 2'h1;
  localparam logic [1:0] HYSTERESIS_SELECT_3P0 = 2'h2;
  localparam logic [1:0] HYSTERESIS_SELECT_6P0 = 2'h3;
  localparam logic [4:0] HYSTERESIS_SELECT_Q_OFF = 5'h00;
  localparam logic [4:0] HYSTERESIS_SELECT_Q_1P5 = 5'h06;
  localparam logic [4:0] HYSTERESIS_SELECT_Q_3P0 = 5'h0c;
  localparam logic [4:0] HYSTERESIS_SELECT_Q_6P0 = 5'h18;

  typedef enum logic {TSAL_CMP_MODE, TSAL_INT_MODE} tsal_mode_t;

endpackage

// ### core/tsal_thresh.sv
// One threshold comparator with falling-side hysteresis
module tsal_thresh #(
  parameter bit LOW_SIDE = 1'b0
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic sample_valid, // New temperature sample
  input wire logic signed [10:0] temp_q, // Temperature B12..B2
  input wire logic signed [10:0] limit_q, // Limit B12..B2
  input wire logic [4:0] hysteresis_select_q, // Hysteresis in quarter degrees
  output logic flag // Out-of-limit condition
);
  import tsal_pkg::*;

  logic signed [12:0] t_ext;
  logic signed [12:0] l_ext;
  logic signed [12:0] l_low;
  logic set_c;
  logic clr_c;

  // Extended by two bits so limit minus hysteresis cannot wrap
  assign t_ext = {{2{temp_q[10]}}, temp_q};
  assign l_ext = {{2{limit_q[10]}}, limit_q};
  assign l_low = l_ext - $signed({8'h00, hysteresis_select_q});

  always_comb begin
    if (LOW_SIDE) begin
      set_c = t_ext < l_low;
      clr_c = t_ext >= l_ext;
    end else begin
      set_c = t_ext > l_ext;
      clr_c = t_ext <= l_low;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (sample_valid) begin
      if (set_c) begin
        flag <= 1'b1;
      end else if (clr_c) begin
        flag <= 1'b0;
      end
    end
  end

endmodule

// ### core/tsal_alarm.sv
// Thermal alarm: register access, window and critical comparators, alarm output
module tsal_alarm (
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic txn_start, // Pulse: addressed transaction begins
  input wire logic [6:0] txn_addr, // Seven-bit bus address of the transaction
  input wire logic txn_read, // Transaction direction, 1 = read
  input wire logic [2:0] addr_sel, // Address select strap
  input wire logic wr_byte_valid, // Pulse: host write byte present
  input wire logic [7:0] wr_byte, // Host write byte
  input wire logic rd_byte_take, // Pulse: host consumed rd_byte
  input wire logic temp_valid, // Pulse: new converter sample
  input wire logic [12:0] temp_data, // Sample B12..B0, two's complement
  input wire logic [15:0] crit_limit, // Critical limit register value
  output logic dev_selected, // Current transaction addresses this device
  output logic [7:0] rd_byte, // Next read byte for the host
  output logic sleep_bit, // Shutdown state
  output logic critical_limit_lock, // Critical limit write lock
  output logic temp_capture_en, // Pulse: temperature data may update
  output logic above_crit, // Above critical threshold
  output logic above_high, // Above upper window limit
  output logic below_low, // Below lower window limit
  output logic alarm_out // Alarm pin level
);
  import tsal_pkg::*;

  //------------------------------------------------------------------
  // Register access
  //------------------------------------------------------------------
  logic [7:0] ptr_reg;
  logic [1:0] byte_cnt_reg;
  logic is_read_reg;
  logic rd_phase_reg;
  logic [7:0] msb_reg;
  logic [15:0] read_word;
  logic sel_c;
  logic commit;
  logic [15:0] wr_word;
  logic cfg_wr;
  logic upper_wr;
  logic lower_wr;

  assign sel_c = txn_addr == {DEV_ADDR_HI, addr_sel};
  assign commit = wr_byte_valid && dev_selected && !is_read_reg && (byte_cnt_reg == 2'h2);
  assign wr_word = {msb_reg, wr_byte};
  assign cfg_wr = commit && (ptr_reg == PTR_ALARM_CONTROL);
  assign upper_wr = commit && (ptr_reg == PTR_UPPER_LIMIT);
  assign lower_wr = commit && (ptr_reg == PTR_LOWER_LIMIT);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dev_selected <= 1'b0;
      is_read_reg <= 1'b0;
    end else if (txn_start) begin
      dev_selected <= sel_c;
      is_read_reg <= txn_read;
    end
  end

  // First write byte is the pointer, then MSB, then LSB commits the word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      byte_cnt_reg <= 2'h0;
    end else if (txn_start) begin
      byte_cnt_reg <= 2'h0;
    end else if (wr_byte_valid && dev_selected && !is_read_reg && byte_cnt_reg != 2'h3) begin
      byte_cnt_reg <= byte_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr_reg <= PTR_RESET;
      msb_reg <= 8'h00;
    end else if (wr_byte_valid && dev_selected && !is_read_reg) begin
      if (byte_cnt_reg == 2'h0) begin
        ptr_reg <= wr_byte;
      end
      if (byte_cnt_reg == 2'h1) begin
        msb_reg <= wr_byte;
      end
    end
  end

  //------------------------------------------------------------------
  // Alarm control and limit registers
  //------------------------------------------------------------------
  logic [1:0] hysteresis_select_reg;
  logic win_lock_reg;
  logic enable_reg;
  logic crit_only_reg;
  logic pol_reg;
  tsal_mode_t mode_reg;
  logic [10:0] upper_reg;
  logic [10:0] lower_reg;
  logic any_lock;
  logic clear_pulse;

  assign any_lock = critical_limit_lock || win_lock_reg;
  // Clear acts only in interrupt mode; it is never stored
  assign clear_pulse = cfg_wr && wr_word[CFG_CLEAR] && (mode_reg == TSAL_INT_MODE);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      critical_limit_lock <= ALARM_CONTROL_RESET[CFG_CRIT_LOCK];
      win_lock_reg <= ALARM_CONTROL_RESET[CFG_WIN_LOCK];
    end else if (cfg_wr) begin
      critical_limit_lock <= critical_limit_lock || wr_word[CFG_CRIT_LOCK];
      win_lock_reg <= win_lock_reg || wr_word[CFG_WIN_LOCK];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleep_bit <= ALARM_CONTROL_RESET[CFG_SLEEP];
    end else if (cfg_wr) begin
      if (any_lock) begin
        sleep_bit <= sleep_bit && wr_word[CFG_SLEEP];
      end else begin
        sleep_bit <= wr_word[CFG_SLEEP];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hysteresis_select_reg <= ALARM_CONTROL_RESET[CFG_HYSTERESIS_SELECT_HI:CFG_HYSTERESIS_SELECT_LO];
      enable_reg <= ALARM_CONTROL_RESET[CFG_ENABLE];
      pol_reg <= ALARM_CONTROL_RESET[CFG_POLARITY];
      mode_reg <= tsal_mode_t'(ALARM_CONTROL_RESET[CFG_MODE]);
    end else if (cfg_wr && !any_lock) begin
      hysteresis_select_reg <= wr_word[CFG_HYSTERESIS_SELECT_HI:CFG_HYSTERESIS_SELECT_LO];
      enable_reg <= wr_word[CFG_ENABLE];
      pol_reg <= wr_word[CFG_POLARITY];
      mode_reg <= tsal_mode_t'(wr_word[CFG_MODE]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      crit_only_reg <= ALARM_CONTROL_RESET[CFG_CRIT_ONLY];
    end else if (cfg_wr && !win_lock_reg) begin
      crit_only_reg <= wr_word[CFG_CRIT_ONLY];
    end
  end

  // Only B12..B2 are kept; unused bits read back as zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      upper_reg <= LIMIT_RESET;
      lower_reg <= LIMIT_RESET;
    end else if (!win_lock_reg) begin
      if (upper_wr) begin
        upper_reg <= wr_word[LIM_MSB:LIM_LSB];
      end
      if (lower_wr) begin
        lower_reg <= wr_word[LIM_MSB:LIM_LSB];
      end
    end
  end

  //------------------------------------------------------------------
  // Comparators
  //------------------------------------------------------------------
  logic [4:0] hysteresis_select_q;
  logic sample_en;

  always_comb begin
    unique case (hysteresis_select_reg)
      HYSTERESIS_SELECT_OFF: hysteresis_select_q = HYSTERESIS_SELECT_Q_OFF;
      HYSTERESIS_SELECT_1P5: hysteresis_select_q = HYSTERESIS_SELECT_Q_1P5;
      HYSTERESIS_SELECT_3P0: hysteresis_select_q = HYSTERESIS_SELECT_Q_3P0;
      HYSTERESIS_SELECT_6P0: hysteresis_select_q = HYSTERESIS_SELECT_Q_6P0;
    endcase
  end

  // Sleep drops samples, so flags and data freeze
  assign sample_en = temp_valid && !sleep_bit;
  assign temp_capture_en = sample_en;

  tsal_thresh #(.LOW_SIDE(1'b0)) u_crit (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sample_valid(sample_en),
    .temp_q(temp_data[LIM_MSB:LIM_LSB]),
    .limit_q(crit_limit[LIM_MSB:LIM_LSB]),
    .hysteresis_select_q(hysteresis_select_q),
    .flag(above_crit)
  );

  tsal_thresh #(.LOW_SIDE(1'b0)) u_high (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sample_valid(sample_en),
    .temp_q(temp_data[LIM_MSB:LIM_LSB]),
    .limit_q(upper_reg),
    .hysteresis_select_q(hysteresis_select_q),
    .flag(above_high)
  );

  tsal_thresh #(.LOW_SIDE(1'b1)) u_low (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sample_valid(sample_en),
    .temp_q(temp_data[LIM_MSB:LIM_LSB]),
    .limit_q(lower_reg),
    .hysteresis_select_q(hysteresis_select_q),
    .flag(below_low)
  );

  //------------------------------------------------------------------
  // Alarm output
  //------------------------------------------------------------------
  logic cond_c;
  logic cond_prev_reg;
  logic pend_reg;
  logic pend_next;
  logic alarm_active_reg;
  logic alarm_next;

  assign cond_c = above_crit || (!crit_only_reg && (above_high || below_low));

  always_comb begin
    pend_next = pend_reg;
    if (sleep_bit) begin
      pend_next = 1'b0;
    end else if (cond_c && !cond_prev_reg) begin
      pend_next = 1'b1;
    end else if (clear_pulse) begin
      pend_next = 1'b0;
    end
    if (mode_reg == TSAL_INT_MODE) begin
      alarm_next = pend_next;
    end else begin
      alarm_next = cond_c;
    end
    alarm_next = alarm_next && enable_reg && !sleep_bit;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cond_prev_reg <= 1'b0;
      pend_reg <= 1'b0;
      alarm_active_reg <= 1'b0;
    end else begin
      cond_prev_reg <= cond_c && !sleep_bit;
      pend_reg <= pend_next;
      alarm_active_reg <= alarm_next;
    end
  end

  // Pin level decoded from the live polarity so a change shows at once
  assign alarm_out = alarm_active_reg ? pol_reg : !pol_reg;

  //------------------------------------------------------------------
  // Read path
  //------------------------------------------------------------------
  always_comb begin
    read_word = 16'h0000;
    unique case (ptr_reg)
      PTR_ALARM_CONTROL: begin
        read_word[CFG_HYSTERESIS_SELECT_HI:CFG_HYSTERESIS_SELECT_LO] = hysteresis_select_reg;
        read_word[CFG_SLEEP] = sleep_bit;
        read_word[CFG_CRIT_LOCK] = critical_limit_lock;
        read_word[CFG_WIN_LOCK] = win_lock_reg;
        read_word[CFG_STATUS] = alarm_active_reg;
        read_word[CFG_ENABLE] = enable_reg;
        read_word[CFG_CRIT_ONLY] = crit_only_reg;
        read_word[CFG_POLARITY] = pol_reg;
        read_word[CFG_MODE] = mode_reg;
      end
      PTR_UPPER_LIMIT: read_word[LIM_MSB:LIM_LSB] = upper_reg;
      PTR_LOWER_LIMIT: read_word[LIM_MSB:LIM_LSB] = lower_reg;
      default: read_word = 16'h0000;
    endcase
  end

  // Reads answer regardless of sleep; MSB first, then LSB, then wraps
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_phase_reg <= 1'b0;
      rd_byte <= 8'h00;
    end else if (txn_start) begin
      rd_phase_reg <= 1'b0;
      if (txn_read && sel_c) begin
        rd_byte <= read_word[15:8];
      end
    end else if (rd_byte_take && dev_selected && is_read_reg) begin
      rd_phase_reg <= !rd_phase_reg;
      rd_byte <= rd_phase_reg ? read_word[15:8] : read_word[7:0];
    end
  end

  //------------------------------------------------------------------
  // Checks
  //------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_cfg_read_start;
    txn_start && txn_read && sel_c && ptr_reg == PTR_ALARM_CONTROL;
  endsequence

  sequence s_cfg_lsb_take;
    rd_byte_take && dev_selected && is_read_reg && !rd_phase_reg && !txn_start &&
      ptr_reg == PTR_ALARM_CONTROL;
  endsequence

  a_reserved_read_zero: assert property (s_cfg_read_start |=> rd_byte[7:3] == 5'h00)
    else $error("reserved control bits read nonzero");
  a_status_read_match: assert property (s_cfg_lsb_take |=> rd_byte[4] == $past(alarm_active_reg))
    else $error("status bit differs from alarm state");
  a_clear_reads_zero: assert property (s_cfg_lsb_take |=> rd_byte[5] == 1'b0)
    else $error("clear bit read as one");
  a_crit_lock_sticky: assert property (critical_limit_lock |=> critical_limit_lock)
    else $error("critical lock dropped");
  a_win_lock_limits: assert property (win_lock_reg |=> $stable(upper_reg) && $stable(lower_reg))
    else $error("limit changed under window lock");
  a_hysteresis_select_locked: assert property (any_lock |=> $stable(hysteresis_select_reg) && $stable(pol_reg))
    else $error("locked field changed");
  a_sleep_no_set: assert property (any_lock && !sleep_bit |=> !sleep_bit)
    else $error("sleep set while locked");
  // Capture is gated in the same cycle; the alarm register only drops one edge later
  a_sleep_no_update: assert property (sleep_bit |-> !temp_capture_en)
    else $error("data update during sleep");
  a_sleep_alarm_off: assert property (sleep_bit |=> !alarm_active_reg)
    else $error("alarm active during sleep");
  a_disabled_idle: assert property (!enable_reg ##1 !enable_reg |-> alarm_out == !pol_reg)
    else $error("disabled alarm driven active");
  a_cmp_tracks: assert property (mode_reg == TSAL_CMP_MODE && enable_reg && !sleep_bit && cond_c
    |=> alarm_active_reg)
    else $error("comparator alarm not following condition");
  a_int_holds: assert property (mode_reg == TSAL_INT_MODE && alarm_active_reg && enable_reg &&
    !sleep_bit && !clear_pulse |=> alarm_active_reg || !enable_reg || sleep_bit)
    else $error("interrupt alarm released without clear");
  a_int_latches: assert property (mode_reg == TSAL_INT_MODE && enable_reg && !sleep_bit &&
    cond_c && !cond_prev_reg |=> alarm_active_reg)
    else $error("interrupt alarm missed a new event");
  a_mode_locked: assert property (any_lock |=> $stable(enable_reg) && $stable(mode_reg))
    else $error("enable or mode changed under lock");
  a_crit_only_lock: assert property (win_lock_reg |=> $stable(crit_only_reg))
    else $error("critical-only changed under window lock");
  a_win_lock_sticky: assert property (win_lock_reg |=> win_lock_reg)
    else $error("window lock dropped");
  a_sleep_clearable: assert property (cfg_wr && !wr_word[CFG_SLEEP] |=> !sleep_bit)
    else $error("sleep clear refused");
  a_clear_releases: assert property (clear_pulse && !sleep_bit && !(cond_c && !cond_prev_reg)
    |=> !pend_reg)
    else $error("clear did not release pending alarm");

endmodule

// ### tb/tsal_host.sv
// Host-side model of the serial bus engine that feeds the register port
module tsal_host (
  input wire logic clk_sys, // System clock
  input wire logic [2:0] addr_sel, // Strap value the device answers to
  output logic txn_start, // Pulse: transaction addressed
  output logic [6:0] txn_addr, // Seven-bit bus address
  output logic txn_read, // Direction, 1 = read
  output logic wr_byte_valid, // Pulse: write byte present
  output logic [7:0] wr_byte, // Write byte
  output logic rd_byte_take, // Pulse: read byte consumed
  input wire logic [7:0] rd_byte // Read byte from the device
);
  timeunit 1ns;
  timeprecision 1ns;

  // Set while the converter runs at half-degree steps
  bit half_step = 1'b0;

  initial begin
    txn_start = 1'b0;
    txn_addr = 7'h00;
    txn_read = 1'b0;
    wr_byte_valid = 1'b0;
    wr_byte = 8'h00;
    rd_byte_take = 1'b0;
  end

  //------------------------------------------------------------------
  // Transfers
  //------------------------------------------------------------------
  task automatic start(input bit rd, input bit alien);
    @(posedge clk_sys);
    txn_start <= 1'b1;
    txn_addr <= alien ? 7'h7f : {4'h3, addr_sel};
    txn_read <= rd;
    @(posedge clk_sys);
    txn_start <= 1'b0;
    // Released lines never keep the last value
    txn_addr <= ~txn_addr;
    txn_read <= ~rd;
  endtask

  task automatic put(input logic [7:0] b);
    wr_byte_valid <= 1'b1;
    wr_byte <= b;
    @(posedge clk_sys);
  endtask

  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] data, input bit raw,
                           input bit alien);
    logic [15:0] d;
    d = data;
    // A well-behaved host zeroes reserved and unused bits
    if (!raw) d = d & ((ptr == 8'h01) ? 16'h07ff : 16'h1ffc);
    if (!raw && half_step && ptr != 8'h01) d[2] = 1'b0;
    start(1'b0, alien);
    put(ptr);
    put(d[15:8]);
    put(d[7:0]);
    wr_byte_valid <= 1'b0;
    wr_byte <= ~d[7:0];
  endtask

  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] data);
    start(1'b0, 1'b0);
    put(ptr);
    wr_byte_valid <= 1'b0;
    wr_byte <= ~ptr;
    start(1'b1, 1'b0);
    rd_byte_take <= 1'b1;
    @(negedge clk_sys);
    data[15:8] = rd_byte;
    @(posedge clk_sys);
    rd_byte_take <= 1'b0;
    @(negedge clk_sys);
    data[7:0] = rd_byte;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking testbench of the thermal alarm block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tsal_pkg::*;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr_sel = 3'h5;
  logic temp_valid = 1'b0;
  logic [12:0] temp_data = 13'h0000;
  logic [15:0] crit_limit = 16'h0500;
  logic txn_start, txn_read, wr_byte_valid, rd_byte_take;
  logic [6:0] txn_addr;
  logic [7:0] wr_byte, rd_byte;
  logic sleep_bit, critical_limit_lock, temp_capture_en;
  logic above_crit, above_high, below_low, alarm_out;
  logic cap;
  logic dev_sel;
  logic [15:0] v;
  int error_cnt = 0;
  int num_checks = 0;
  int hq [4] = '{0, 6, 12, 24};

  always #25 clk_sys = ~clk_sys;

  tsal_host tsal_host_inst (.clk_sys(clk_sys), .addr_sel(addr_sel), .txn_start(txn_start),
    .txn_addr(txn_addr), .txn_read(txn_read), .wr_byte_valid(wr_byte_valid),
    .wr_byte(wr_byte), .rd_byte_take(rd_byte_take), .rd_byte(rd_byte));

  tsal_alarm tsal_alarm_inst (.clk_sys(clk_sys), .rst_n(rst_n), .txn_start(txn_start),
    .txn_addr(txn_addr), .txn_read(txn_read), .addr_sel(addr_sel),
    .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_take(rd_byte_take),
    .temp_valid(temp_valid), .temp_data(temp_data), .crit_limit(crit_limit),
    .dev_selected(dev_sel), .rd_byte(rd_byte), .sleep_bit(sleep_bit),
    .critical_limit_lock(critical_limit_lock), .temp_capture_en(temp_capture_en),
    .above_crit(above_crit), .above_high(above_high), .below_low(below_low),
    .alarm_out(alarm_out));

  //------------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    tsal_host_inst.write_reg(p, d, 1'b0, 1'b0);
    // Commit, then three more cycles for the registered alarm state
    repeat (3) @(posedge clk_sys);
    // Look at outputs away from the edge that updates them
    @(negedge clk_sys);
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
    tsal_host_inst.read_reg(p, v);
    chk(v, exp);
  endtask

  // Temperature in quarter degrees plus the two finer bits
  task automatic heat(input int q, input logic [1:0] f);
    @(posedge clk_sys);
    temp_valid <= 1'b1;
    temp_data <= {q[10:0], f};
    @(negedge clk_sys);
    cap = temp_capture_en;
    @(posedge clk_sys);
    temp_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Order: critical, high, low, pin level
  task automatic flags(input logic [3:0] e);
    chk({12'h000, above_crit, above_high, below_low, alarm_out}, {12'h000, e});
  endtask

  function automatic logic [15:0] lim(input int q);
    return {3'b000, q[10:0], 2'b00};
  endfunction

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  //------------------------------------------------------------------
  // Tests
  //------------------------------------------------------------------
  initial begin
    do_reset();
    rd_chk(PTR_ALARM_CONTROL, 16'h0000);
    rd_chk(PTR_UPPER_LIMIT, 16'h0000);
    chk({15'h0000, alarm_out}, 16'h0001);
    tsal_host_inst.write_reg(PTR_ALARM_CONTROL, 16'hf800, 1'b1, 1'b0);
    rd_chk(PTR_ALARM_CONTROL, 16'h0000);
    wr(PTR_ALARM_CONTROL, 16'h0020);
    rd_chk(PTR_ALARM_CONTROL, 16'h0000);
    rd_chk(8'h07, 16'h0000);
    tsal_host_inst.write_reg(PTR_LOWER_LIMIT, 16'hffff, 1'b1, 1'b0);
    rd_chk(PTR_LOWER_LIMIT, 16'h1ffc);
    tsal_host_inst.half_step = 1'b1;
    wr(PTR_UPPER_LIMIT, lim(161));
    tsal_host_inst.half_step = 1'b0;
    rd_chk(PTR_UPPER_LIMIT, 16'h0280);
    wr(PTR_UPPER_LIMIT, lim(160));
    wr(PTR_LOWER_LIMIT, lim(-11));
    rd_chk(PTR_UPPER_LIMIT, 16'h0280);
    rd_chk(PTR_LOWER_LIMIT, 16'h1fd4);
    tsal_host_inst.write_reg(PTR_ALARM_CONTROL, 16'h0008, 1'b0, 1'b1);
    @(negedge clk_sys);
    chk({15'h0000, dev_sel}, 16'h0000);
    rd_chk(PTR_ALARM_CONTROL, 16'h0000);
    chk({15'h0000, dev_sel}, 16'h0001);
    note("registers");

    for (int h = 0; h < 4; h++) begin
      wr(PTR_ALARM_CONTROL, {5'h00, h[1:0], 9'h008});
      rd_chk(PTR_ALARM_CONTROL, {5'h00, h[1:0], 9'h008});
      heat(100, 2'h0);
      heat(161, 2'h0);
      flags(4'b0100);
      heat(161 - hq[h], 2'h0);
      flags(4'b0100);
      heat(160 - hq[h], 2'h3);
      flags(4'b0001);
    end
    note("hysteresis");

    wr(PTR_ALARM_CONTROL, 16'h0008);
    heat(-12, 2'h0);
    flags(4'b0010);
    chk({15'h0000, cap}, 16'h0001);
    heat(-11, 2'h0);
    flags(4'b0001);
    heat(161, 2'h0);
    wr(PTR_ALARM_CONTROL, 16'h0028);
    flags(4'b0100);
    rd_chk(PTR_ALARM_CONTROL, 16'h0018);
    wr(PTR_ALARM_CONTROL, 16'h0000);
    flags(4'b0101);
    rd_chk(PTR_ALARM_CONTROL, 16'h0000);
    wr(PTR_ALARM_CONTROL, 16'h000a);
    flags(4'b0101);
    heat(100, 2'h0);
    flags(4'b0000);
    note("comparator");

    wr(PTR_ALARM_CONTROL, 16'h0009);
    heat(161, 2'h0);
    flags(4'b0100);
    heat(100, 2'h0);
    flags(4'b0000);
    rd_chk(PTR_ALARM_CONTROL, 16'h0019);
    wr(PTR_ALARM_CONTROL, 16'h0029);
    flags(4'b0001);
    rd_chk(PTR_ALARM_CONTROL, 16'h0009);
    note("interrupt");

    wr(PTR_ALARM_CONTROL, 16'h000c);
    heat(161, 2'h0);
    flags(4'b0101);
    heat(321, 2'h0);
    flags(4'b1100);
    heat(320, 2'h0);
    flags(4'b0101);
    heat(321, 2'h0);
    wr(PTR_ALARM_CONTROL, 16'h010c);
    flags(4'b1101);
    heat(100, 2'h0);
    chk({15'h0000, cap}, 16'h0000);
    flags(4'b1101);
    rd_chk(PTR_ALARM_CONTROL, 16'h010c);
    wr(PTR_ALARM_CONTROL, 16'h000c);
    chk({15'h0000, sleep_bit}, 16'h0000);
    heat(100, 2'h0);
    flags(4'b0001);
    note("critical and sleep");

    wr(PTR_ALARM_CONTROL, 16'h0100);
    wr(PTR_ALARM_CONTROL, 16'h0180);
    rd_chk(PTR_ALARM_CONTROL, 16'h0180);
    chk({15'h0000, critical_limit_lock}, 16'h0001);
    wr(PTR_ALARM_CONTROL, 16'h0080);
    rd_chk(PTR_ALARM_CONTROL, 16'h0080);
    wr(PTR_ALARM_CONTROL, 16'h0f8f);
    rd_chk(PTR_ALARM_CONTROL, 16'h0084);
    wr(PTR_ALARM_CONTROL, 16'h0000);
    rd_chk(PTR_ALARM_CONTROL, 16'h0080);
    wr(PTR_ALARM_CONTROL, 16'h00c4);
    wr(PTR_ALARM_CONTROL, 16'h0080);
    rd_chk(PTR_ALARM_CONTROL, 16'h00c4);
    wr(PTR_UPPER_LIMIT, lim(200));
    rd_chk(PTR_UPPER_LIMIT, 16'h0280);
    wr(PTR_LOWER_LIMIT, lim(0));
    rd_chk(PTR_LOWER_LIMIT, 16'h1fd4);
    @(posedge clk_sys);
    do_reset();
    rd_chk(PTR_ALARM_CONTROL, 16'h0000);
    chk({15'h0000, critical_limit_lock}, 16'h0000);
    note("locks");
    wrap_up();
  end

  // Full run is under a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end
endmodule
